// ==== design/sbm_cfg.svh ====
/*
 Constants of the bit shift master: command port offsets, field
 positions, reset values and timing counts.
 Assumes a 100 MHz core clock and an 8-bit command port.
*/
`ifndef SBM_CFG_SVH
`define SBM_CFG_SVH

// ==========================================================
// Timing
`define SBM_CLK_NS 10
`define SBM_PIN_LAG_NS 1000
`define SBM_PIN_LAG_CYC ((`SBM_PIN_LAG_NS+`SBM_CLK_NS-1)/`SBM_CLK_NS)

// ==========================================================
// Command port offsets
`define SBM_A_MODE 8'h00
`define SBM_A_TX 8'h01
`define SBM_A_RDREQ 8'h02
`define SBM_A_RX 8'h03
`define SBM_A_STATUS 8'h04
`define SBM_A_CTRL 8'h05
`define SBM_A_TIMING 8'h06
`define SBM_A_BUS 8'h07
`define SBM_A_PIN_DATA 8'h08
`define SBM_A_PIN_DIR 8'h09
`define SBM_A_PIN_SNAP 8'h0A

// ==========================================================
// Fields and values
`define SBM_F_CNT_GIVEN 4
`define SBM_F_ECHO 6
`define SBM_FULL_LEN 4'h8
`define SBM_BIDIR_MIN 4'h8
`define SBM_CTRL_RST 8'h08
`define SBM_DIR_RST 8'hFF
`define SBM_TIMING_RST 8'h00
`define SBM_BUS_RST 4'h0
`define SBM_BUS_SPLIT_A 4'h9
`define SBM_BUS_SPLIT_B 4'hA

`endif

// ==== design/sbm_pkg.sv ====
/*
 Types of the bit shift master.
 Assumes nothing beyond the compiler.
*/
package sbm_pkg;

    // ======================================================
    // Shift engine phases
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_NEXT,
        ST_LOW,
        ST_HIGH,
        ST_FIN
    } sbm_shift_e;

endpackage

// ==== design/sbm_shifter.sv ====
/*
 Shift engine: clocks one unit of 1 to 8 bits MSB first, samples
 the input at the end of each clock high phase.
 Assumes din is already synchronised to clk.
*/
`timescale 1ns/10ps
`include "sbm_cfg.svh"
module sbm_shifter
(
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset
    input wire logic start, // Begin a unit
    input wire logic [3:0] len, // Bits in the unit
    input wire logic [7:0] tx, // Write data, right aligned
    input wire logic drive, // Drive data line in unit
    input wire logic [7:0] timing, // Half period minus one
    input wire logic din, // Synchronised data input
    output logic sck, // Shift clock
    output logic dout, // Data output
    output logic dout_oe, // Data output enable
    output logic busy, // Unit in progress
    output logic done, // One cycle at unit end
    output logic [7:0] rx // Captured bits, right aligned
);
    sbm_pkg::sbm_shift_e state; // Bit phase
    logic [7:0] shreg; // Outgoing bits
    logic [7:0] tmr; // Half period countdown
    logic [3:0] left; // Bits still to clock
    logic [3:0] len_q; // Length of this unit
    logic drive_q; // Drive held for the unit

    // ======================================================
    // Bit sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= sbm_pkg::ST_IDLE;
            shreg <= 8'h00;
            tmr <= 8'h00;
            left <= 4'h0;
            len_q <= `SBM_FULL_LEN;
            drive_q <= 1'b0;
            sck <= 1'b0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rx <= 8'h00;
        end
        else
        begin
            done <= 1'b0;
            case (state)
            sbm_pkg::ST_IDLE:
            begin
                // Short data sits in the low bits; align to MSB
                if (start)
                begin
                    shreg <= tx << (`SBM_FULL_LEN - len);
                    rx <= 8'h00;
                    left <= len;
                    len_q <= len;
                    drive_q <= drive;
                    busy <= 1'b1;
                    state <= sbm_pkg::ST_NEXT;
                end
            end
            sbm_pkg::ST_NEXT:
            begin
                // Data moves one cycle after the clock fell
                dout <= shreg[7];
                shreg <= {shreg[6:0], 1'b0};
                dout_oe <= drive_q;
                tmr <= timing;
                state <= sbm_pkg::ST_LOW;
            end
            sbm_pkg::ST_LOW:
            begin
                // Clock rises a half period after the data
                if (tmr == 8'h00)
                begin
                    sck <= 1'b1;
                    tmr <= timing;
                    state <= sbm_pkg::ST_HIGH;
                end
                else
                begin
                    tmr <= tmr - 8'h01;
                end
            end
            sbm_pkg::ST_HIGH:
            begin
                // Sample just before the falling edge
                if (tmr == 8'h00)
                begin
                    rx <= {rx[6:0], din};
                    sck <= 1'b0;
                    left <= left - 4'h1;
                    if (left == 4'h1)
                    begin
                        state <= sbm_pkg::ST_FIN;
                    end
                    else
                    begin
                        state <= sbm_pkg::ST_NEXT;
                    end
                end
                else
                begin
                    tmr <= tmr - 8'h01;
                end
            end
            default:
            begin
                // Clock left low, driver released
                done <= 1'b1;
                busy <= 1'b0;
                dout_oe <= 1'b0;
                state <= sbm_pkg::ST_IDLE;
            end
            endcase
        end
    end

    // ======================================================
    // Checks
    chk_edges_apart: assert property (@(posedge clk) disable iff (rst)
        $changed(sck) |-> $stable(dout))
        else $error("clock and data changed together");
    chk_sample_high: assert property (@(posedge clk) disable iff (rst)
        (state == sbm_pkg::ST_HIGH && tmr == 8'h00) |-> sck)
        else $error("sample taken with clock low");
    chk_msb_first: assert property (@(posedge clk) disable iff (rst)
        (state == sbm_pkg::ST_IDLE && start && len == `SBM_FULL_LEN)
        |=> ##1 dout == $past(tx[7], 2))
        else $error("first bit is not the MSB");
    chk_right_align: assert property (@(posedge clk) disable iff (rst)
        done |-> (rx >> len_q) == 8'h00)
        else $error("short read not zero filled");
    chk_sck_rest: assert property (@(posedge clk) disable iff (rst)
        !busy |-> !sck)
        else $error("clock not low between units");

endmodule

// ==== design/sbm_spi_bit_shift_master.sv ====
/*
 Command driven serial shift master: mode command, write and read
 units, bidirectional echo, bus selection and direct pin port.
 Assumes a command master on clk with one-cycle strobes; the data
 and pin inputs come from outside and are synchronised here.
*/
// The strobed register port and the register addresses were chosen for this implementation.
// Summary of operation
// - Full units are 8 bits, MSB first
// - Engine never drives select; host uses pins
// - Mode command enters; count 0 leaves
// - Pins 0-4 first, 3-7 one microsecond later
// - Given count shortens only the next unit
// - Short data right aligned, zero filled
// - Count 8-15 selects bidirectional mode
// - Bidirectional: one byte back per byte
// - Mode command without count leaves bidirectional
// - Bus selection clears echo flag
// - Data accepted right after mode command
// - Clock and data never change together
// - Sample while clock high, before fall
// - Clock rests low between units
// - Split buses use separate data in
// - Echo flag is control bit 6, reset 0
// - One timing value for all buses
`timescale 1ns/10ps
`include "sbm_cfg.svh"
module sbm_spi_bit_shift_master
(
    input wire logic clk, // Core clock, 100 MHz
    input wire logic rst, // Synchronous reset
    input wire logic [7:0] addr, // Command port address
    input wire logic [7:0] wdata, // Command port write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [7:0] rdata, // Read data, cycle after rd
    output logic sck, // Shift clock line
    output logic sda_out, // Data line output
    output logic sda_oe, // Data line output enable
    input wire logic sda_in, // Data line level
    input wire logic sdi_in, // Split bus data input
    output logic [7:0] pin_out, // Direct pin outputs
    output logic [7:0] pin_oe, // Direct pin output enables
    input wire logic [7:0] pin_in // Direct pin levels
);
    // ======================================================
    // Declarations
    logic shift_mode; // Shift mode active
    logic [3:0] short_len; // Length of next unit
    logic [7:0] control_register; // Echo flag at bit 6
    logic [7:0] timing; // Global bit timing
    logic [3:0] bus_sel; // Selected bus number
    logic split; // Split data pins selected
    logic [7:0] rx_data; // Last captured unit
    logic rx_valid; // Captured unit not yet read
    logic capture; // Current unit is captured
    logic [7:0] pin_data; // Pin data bits
    logic [7:0] pin_direction_bits; // 1 = input
    logic [7:0] pin_snap; // Staged pin sample
    logic [6:0] pin_cnt; // Upper group delay
    logic pend_out; // Upper outputs pending
    logic pend_snap; // Upper sample pending
    logic [1:0] sda_sync; // Data line synchroniser
    logic [1:0] sdi_sync; // Split input synchroniser
    logic [7:0] pin_s1; // Pin synchroniser stage 1
    logic [7:0] pin_s2; // Pin synchroniser stage 2
    logic din; // Selected data input
    logic echo; // echo_read_on_write
    logic wr_mode; // Mode command
    logic wr_tx; // Write unit request
    logic wr_rdreq; // Read unit request
    logic wr_ctrl; // Control write
    logic wr_timing; // Timing write
    logic wr_bus; // Bus selection
    logic wr_pdata; // Pin data write
    logic wr_pdir; // Pin direction write
    logic wr_psnap; // Pin sample request
    logic busy; // Engine busy
    logic done; // Engine finished a unit
    logic [7:0] eng_rx; // Engine captured bits
    logic start; // Start a unit
    logic start_rd; // Start is a read
    logic [7:0] tx_word; // Data handed to engine
    logic drive; // Drive data line in unit

    // ======================================================
    // Write decode
    always_comb
    begin
        wr_mode = 1'b0;
        wr_tx = 1'b0;
        wr_rdreq = 1'b0;
        wr_ctrl = 1'b0;
        wr_timing = 1'b0;
        wr_bus = 1'b0;
        wr_pdata = 1'b0;
        wr_pdir = 1'b0;
        wr_psnap = 1'b0;
        if (!wr)
        begin
            wr_mode = 1'b0;
        end
        else if (addr == `SBM_A_MODE)
        begin
            wr_mode = 1'b1;
        end
        else if (addr == `SBM_A_TX)
        begin
            wr_tx = 1'b1;
        end
        else if (addr == `SBM_A_RDREQ)
        begin
            wr_rdreq = 1'b1;
        end
        else if (addr == `SBM_A_CTRL)
        begin
            wr_ctrl = 1'b1;
        end
        else if (addr == `SBM_A_TIMING)
        begin
            wr_timing = 1'b1;
        end
        else if (addr == `SBM_A_BUS)
        begin
            wr_bus = 1'b1;
        end
        else if (addr == `SBM_A_PIN_DATA)
        begin
            wr_pdata = 1'b1;
        end
        else if (addr == `SBM_A_PIN_DIR)
        begin
            wr_pdir = 1'b1;
        end
        else if (addr == `SBM_A_PIN_SNAP)
        begin
            wr_psnap = 1'b1;
        end
    end

    // ======================================================
    // Unit launch; host has stopped the bus beforehand
    assign echo = control_register[`SBM_F_ECHO];
    assign start = (wr_tx || wr_rdreq) && shift_mode && !busy;
    assign start_rd = wr_rdreq;
    assign tx_word = start_rd ? 8'h00 : wdata;
    // Shared line is released while reading
    assign drive = split || !start_rd;
    // Split buses read the separate input pin
    assign din = split ? sdi_sync[1] : sda_sync[1];

    // ======================================================
    // Input synchronisers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sda_sync <= 2'b00;
            sdi_sync <= 2'b00;
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
        end
        else
        begin
            sda_sync <= {sda_sync[0], sda_in};
            sdi_sync <= {sdi_sync[0], sdi_in};
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // ======================================================
    // Mode state and one-shot length
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shift_mode <= 1'b0;
            short_len <= `SBM_FULL_LEN;
        end
        else if (wr_mode)
        begin
            // Count 0 leaves, anything else enters
            shift_mode <= !(wdata[`SBM_F_CNT_GIVEN] &&
                wdata[3:0] == 4'h0);
            if (wdata[`SBM_F_CNT_GIVEN] && wdata[3:0] != 4'h0 &&
                wdata[3:0] < `SBM_BIDIR_MIN)
            begin
                short_len <= wdata[3:0];
            end
        end
        else if (start)
        begin
            short_len <= `SBM_FULL_LEN;
        end
    end

    // ======================================================
    // Control register, timing and bus selection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            control_register <= `SBM_CTRL_RST;
            timing <= `SBM_TIMING_RST;
            bus_sel <= `SBM_BUS_RST;
        end
        else if (wr_ctrl)
        begin
            control_register <= wdata;
        end
        else if (wr_timing)
        begin
            timing <= wdata;
        end
        else if (wr_bus)
        begin
            // Timing is global and stays as it is
            bus_sel <= wdata[3:0];
            control_register[`SBM_F_ECHO] <= 1'b0;
        end
        else if (wr_mode && wdata[`SBM_F_CNT_GIVEN] &&
            wdata[3:0] >= `SBM_BIDIR_MIN)
        begin
            control_register[`SBM_F_ECHO] <= 1'b1;
        end
        else if (wr_mode && !wdata[`SBM_F_CNT_GIVEN])
        begin
            control_register[`SBM_F_ECHO] <= 1'b0;
        end
    end

    assign split = bus_sel == `SBM_BUS_SPLIT_A ||
        bus_sel == `SBM_BUS_SPLIT_B;

    // ======================================================
    // Captured data; a new unit wins over the read clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            capture <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
        end
        else
        begin
            if (start)
            begin
                capture <= echo || start_rd;
            end
            if (done && capture)
            begin
                rx_data <= eng_rx;
                rx_valid <= 1'b1;
            end
            else if (rd && addr == `SBM_A_RX)
            begin
                rx_valid <= 1'b0;
            end
        end
    end

    // ======================================================
    // Direct pins; selects are driven only from here
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_data <= 8'h00;
            pin_direction_bits <= `SBM_DIR_RST;
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            pin_snap <= 8'h00;
            pin_cnt <= 7'h00;
            pend_out <= 1'b0;
            pend_snap <= 1'b0;
        end
        else if (wr_pdata || wr_pdir)
        begin
            // Low group now, upper group after the lag
            if (wr_pdata)
            begin
                pin_data <= wdata;
                pin_out[4:0] <= wdata[4:0];
            end
            else
            begin
                pin_direction_bits <= wdata;
                pin_oe[4:0] <= ~wdata[4:0];
            end
            pin_cnt <= 7'(`SBM_PIN_LAG_CYC);
            pend_out <= 1'b1;
        end
        else if (wr_psnap)
        begin
            pin_snap[4:0] <= pin_s2[4:0];
            pin_cnt <= 7'(`SBM_PIN_LAG_CYC);
            pend_snap <= 1'b1;
        end
        else if (pin_cnt == 7'h01)
        begin
            // Upper group, bits 3 to 7
            if (pend_out)
            begin
                pin_out[7:3] <= pin_data[7:3];
                pin_oe[7:3] <= ~pin_direction_bits[7:3];
            end
            if (pend_snap)
            begin
                pin_snap[7:3] <= pin_s2[7:3];
            end
            pin_cnt <= 7'h00;
            pend_out <= 1'b0;
            pend_snap <= 1'b0;
        end
        else if (pin_cnt != 7'h00)
        begin
            pin_cnt <= pin_cnt - 7'h01;
        end
    end

    // ======================================================
    // Read data, valid only in the cycle after rd
    always_ff @(posedge clk)
    begin
        if (rst || !rd)
        begin
            rdata <= 8'h00;
        end
        else if (addr == `SBM_A_RX)
        begin
            rdata <= rx_data;
        end
        else if (addr == `SBM_A_STATUS)
        begin
            rdata <= {3'b000, split, rx_valid, echo, shift_mode, busy};
        end
        else if (addr == `SBM_A_CTRL)
        begin
            rdata <= control_register;
        end
        else if (addr == `SBM_A_TIMING)
        begin
            rdata <= timing;
        end
        else if (addr == `SBM_A_BUS)
        begin
            rdata <= {4'h0, bus_sel};
        end
        else if (addr == `SBM_A_PIN_DATA)
        begin
            rdata <= pin_data;
        end
        else if (addr == `SBM_A_PIN_DIR)
        begin
            rdata <= pin_direction_bits;
        end
        else if (addr == `SBM_A_PIN_SNAP)
        begin
            rdata <= pin_snap;
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

    // ======================================================
    // Shift engine
    sbm_shifter u_shift
    (
        .clk(clk),
        .rst(rst),
        .start(start),
        .len(short_len),
        .tx(tx_word),
        .drive(drive),
        .timing(timing),
        .din(din),
        .sck(sck),
        .dout(sda_out),
        .dout_oe(sda_oe),
        .busy(busy),
        .done(done),
        .rx(eng_rx)
    );

    // ======================================================
    // Checks
    chk_mode_exit: assert property (@(posedge clk) disable iff (rst)
        (wr_mode && wdata[`SBM_F_CNT_GIVEN] && wdata[3:0] == 4'h0)
        |=> !shift_mode ##1 !busy)
        else $error("count 0 did not leave shift mode");
    chk_len_revert: assert property (@(posedge clk) disable iff (rst)
        start |=> short_len == `SBM_FULL_LEN)
        else $error("short length not one-shot");
    chk_bidir_enter: assert property (@(posedge clk) disable iff (rst)
        (wr_mode && wdata[`SBM_F_CNT_GIVEN] && wdata[3] && shift_mode)
        |=> echo && shift_mode)
        else $error("count 8-15 missed bidirectional");
    chk_echo_leave: assert property (@(posedge clk) disable iff (rst)
        (wr_mode && !wdata[`SBM_F_CNT_GIVEN]) |=> !echo)
        else $error("bare mode command kept echo");
    chk_bus_clear: assert property (@(posedge clk) disable iff (rst)
        wr_bus |=> !echo && $stable(timing))
        else $error("bus change kept echo or timing");
    chk_echo_back: assert property (@(posedge clk) disable iff (rst)
        (done && capture) |=> rx_valid && rx_data == $past(eng_rx))
        else $error("echo byte not returned");
    chk_pin_lag: assert property (@(posedge clk) disable iff (rst)
        wr_pdata |=> pin_out[4:0] == $past(wdata[4:0]) &&
        pin_cnt == 7'(`SBM_PIN_LAG_CYC))
        else $error("low pin group late");

endmodule

// ==== tb/sbm_periph_model.sv ====
/*
 Behavioural serial peripheral for the bit shift master bench.
 Assumes a select that is low while active, data taken on the
 rising clock edge and reply bits moved on the falling edge.
*/
`timescale 1ns/10ps
module sbm_periph_model
(
    input wire logic sck, // Shift clock from the master
    input wire logic mosi, // Data from the master
    input wire logic cs_n, // Select, low while active
    input wire logic [7:0] reply, // Byte returned MSB first
    output logic miso, // Reply data line
    output logic [7:0] got, // Bits taken, newest at bit 0
    output logic [3:0] nb // Count of bits taken
);
    // ==========================================================
    // Receive and reply
    logic [2:0] idx; // Reply bit position
    // Select is never driven by the engine, only by pins
    // Shift in on rising edge, count bits
    always @(posedge sck or negedge cs_n)
    begin
        if (!cs_n && !sck)
        begin
            got <= 8'h00;
            nb <= 4'h0;
        end
        else
        begin
            got <= {got[6:0], mosi};
            nb <= nb + 4'h1;
        end
    end
    // Reply bit steps once per finished pulse: it moves on the fall
    // and holds through the high phase, MSB first after select
    assign idx = 3'(4'h7 - nb + {3'h0, sck});
    // Unselected: inverse of the bit, so no stale level is seen
    assign miso = cs_n ? ~reply[idx] : reply[idx];
endmodule

// ==== tb/spi_bit_shift_master_tb.sv ====
/*
 Self-checking bench of the bit shift master with one peripheral.
 Assumes the command port map and timing given in sbm_cfg.svh.
*/
`timescale 1ns/10ps
`include "sbm_cfg.svh"
module spi_bit_shift_master_tb;
    // ==========================================================
    // Signals
    logic clk, rst, wr, rd, sck, sda_out, sda_oe, miso;
    logic [7:0] addr, wdata, rdata, pin_out, pin_oe, got, reply, v;
    logic [3:0] nb;
    int bad_count, cmp_count, hi_cyc;
    logic oe_seen, p_sck, p_sda;
    // Shared line: master when enabled, else peripheral
    wire sda_line = sda_oe ? sda_out : miso;
    sbm_spi_bit_shift_master uut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sck(sck),
        .sda_out(sda_out), .sda_oe(sda_oe), .sda_in(sda_line),
        .sdi_in(miso), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_in(pin_out));
    // Select rides on spare pin 4, set by direct pin writes
    sbm_periph_model per (.sck(sck), .mosi(sda_out), .cs_n(pin_out[4]),
        .reply(reply), .miso(miso), .got(got), .nb(nb));
    // ==========================================================
    // Clock, watchdog, line monitor
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        bad_count++;
        test_done;
    end
    // Clock high cycles, drive seen, simultaneous edges
    always @(posedge clk)
    begin
        if (sck === 1'b1)
            hi_cyc++;
        if (sda_oe === 1'b1)
            oe_seen = 1'b1;
        if (sck !== p_sck && sda_out !== p_sda && sda_oe === 1'b1)
            chk(8'h01, 8'h00);
        p_sck = sck;
        p_sda = sda_out;
    end
    // ==========================================================
    // Port tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Select low, one unit, wait for idle, select high
    task automatic xfer(input logic [7:0] a, input logic [7:0] d);
        int n;
        wrr(`SBM_A_PIN_DATA, 8'h00);
        hi_cyc = 0;
        oe_seen = 1'b0;
        wrr(a, d);
        n = 0;
        v = 8'h01;
        while (v[0] === 1'b1 && n < 300)
        begin
            rdr(`SBM_A_STATUS, v);
            n++;
        end
        chk(v[0], 1'b0);
        chk(sck, 1'b0);
        wrr(`SBM_A_PIN_DATA, 8'h10);
    endtask
    task automatic test_done;
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rdr(`SBM_A_CTRL, v);
        chk(v, 8'h08);
        rdr(`SBM_A_PIN_DIR, v);
        chk(v, 8'hFF);
        rdr(8'h3F, v);
        chk(v, 8'h00);
        chk(pin_oe, 8'h00);
    endtask
    // Pin output group timing and direction bits
    task automatic t_pins;
        wrr(`SBM_A_PIN_DIR, 8'hEF);
        wrr(`SBM_A_PIN_DATA, 8'hE5);
        @(posedge clk);
        #1 chk(pin_out & 8'hE7, 8'h05);
        repeat (110) @(posedge clk);
        #1 chk(pin_out, 8'hE5);
        chk(pin_oe, 8'h10);
        // Pin sample: low group at once, upper group after the lag
        wrr(`SBM_A_PIN_SNAP, 8'h00);
        rdr(`SBM_A_PIN_SNAP, v);
        chk(v, 8'h05);
        repeat (110) @(posedge clk);
        rdr(`SBM_A_PIN_SNAP, v);
        chk(v, 8'hE5);
        wrr(`SBM_A_PIN_DATA, 8'h10);
        repeat (110) @(posedge clk);
    endtask
    // Full byte, short unit, revert to full, clock high time
    task automatic t_write;
        wrr(`SBM_A_TIMING, 8'h03);
        wrr(`SBM_A_MODE, 8'h00);
        // Bus is idle and stopped before the first write unit
        xfer(`SBM_A_TX, 8'hA5);
        chk(got, 8'hA5);
        chk(hi_cyc, 32);
        chk(oe_seen, 1'b1);
        wrr(`SBM_A_MODE, 8'h13);
        xfer(`SBM_A_TX, 8'h05);
        chk(nb, 3);
        chk(got & 8'h07, 8'h05);
        xfer(`SBM_A_TX, 8'hAA);
        chk({nb, 4'h0}, 8'h80);
        chk(got, 8'hAA);
    endtask
    // Short and full reads on the shared line
    task automatic t_read;
        reply = 8'h96;
        wrr(`SBM_A_MODE, 8'h12);
        xfer(`SBM_A_RDREQ, 8'h00);
        chk(oe_seen, 1'b0);
        rdr(`SBM_A_RX, v);
        chk(v, 8'h02);
        xfer(`SBM_A_RDREQ, 8'h00);
        rdr(`SBM_A_RX, v);
        chk(v, 8'h96);
    endtask
    // Echo on split bus, bus change, leaving modes
    task automatic t_modes;
        wrr(`SBM_A_BUS, 8'h09);
        wrr(`SBM_A_MODE, 8'h18);
        rdr(`SBM_A_STATUS, v);
        chk(v & 8'h16, 8'h16);
        reply = 8'h3C;
        xfer(`SBM_A_TX, 8'hC3);
        chk(hi_cyc, 32);
        rdr(`SBM_A_STATUS, v);
        chk(v[3], 1'b1);
        rdr(`SBM_A_RX, v);
        chk(v, 8'h3C);
        rdr(`SBM_A_STATUS, v);
        chk(v[3], 1'b0);
        wrr(`SBM_A_MODE, 8'h00);
        rdr(`SBM_A_STATUS, v);
        chk(v & 8'h06, 8'h02);
        wrr(`SBM_A_MODE, 8'h18);
        wrr(`SBM_A_BUS, 8'h00);
        rdr(`SBM_A_STATUS, v);
        chk(v[2], 1'b0);
        wrr(`SBM_A_MODE, 8'h10);
        rdr(`SBM_A_STATUS, v);
        chk(v[1], 1'b0);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        reply = 8'h00;
        bad_count = 0;
        cmp_count = 0;
        hi_cyc = 0;
        oe_seen = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_pins;
        t_write;
        t_read;
        t_modes;
        test_done;
    end
endmodule
